// File: rtl/fault_vector_status_regs.sv
// Usage fault flags, banked vector table base and combined program status.
// Assumes privilege, security and debugger qualifiers arrive with each strobe,
// and that the core supplies live status and takes writes to it.
`timescale 1ns/1ps
`default_nettype none

module fault_vector_status_regs
  import fvs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic priv_i,
  input wire logic secure_i,
  input wire logic debug_i,
  output logic [31:0] rdata_o,
  output logic bus_fault_o,
  // Fault events from the pipeline
  input wire logic [NUM_FAULTS-1:0] fault_evt_i,
  // Live status from the core
  input wire logic [4:0] application_flags_i,
  input wire logic [3:0] greater_equal_flags_i,
  input wire logic thumb_i,
  input wire logic [7:0] if_then_state_i,
  input wire logic [7:0] interrupt_continuation_i,
  input wire logic [8:0] exception_number_i,
  // Status write to the core
  output logic status_wr_o,
  output logic [4:0] application_flags_o,
  output logic [3:0] greater_equal_flags_o,
  output logic thumb_o,
  output logic [7:0] cond_state_o,
  output logic cond_is_if_then_o,
  output logic [8:0] exception_number_o,
  // Vector table bases
  output logic [31:0] vtb_secure_o,
  output logic [31:0] vtb_nonsecure_o,
  // Fault flags and interrupt
  output logic [NUM_FAULTS-1:0] usage_fault_status_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic bus_fault;
    logic [31:0] vtb_s;
    logic [31:0] vtb_ns;
    logic [NUM_IRQ-1:0] irq_en;
    logic irq;
    logic status_wr;
    logic [4:0] app_flags;
    logic [3:0] gteq_flags;
    logic thumb;
    logic [7:0] cond_state;
    logic cond_is_if_then;
    logic [8:0] exc_num;
  } regs_state_type;

  localparam regs_state_type STATE_RESET = '{
    rdata: '0,
    bus_fault: 1'b0,
    vtb_s: VTB_RESET,
    vtb_ns: VTB_RESET,
    irq_en: IRQ_RESET,
    irq: 1'b0,
    status_wr: 1'b0,
    app_flags: '0,
    gteq_flags: '0,
    thumb: 1'b0,
    cond_state: '0,
    cond_is_if_then: 1'b0,
    exc_num: '0
  };

  regs_state_type cur_ff;
  regs_state_type nxt_state;

  logic [NUM_FAULTS-1:0] ufs_flags;
  logic [NUM_FAULTS-1:0] ufs_clr;
  logic [NUM_IRQ-1:0] irq_flags;
  logic [NUM_IRQ-1:0] irq_clr;
  logic [NUM_IRQ-1:0] irq_set;
  logic access_fault;
  logic [31:0] live_cond;

  // ----------------------------------------------------------------
  // Field helpers
  // ----------------------------------------------------------------
  // Write-ignored base bits keep their old value
  function automatic logic [31:0] vtb_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v);
    vtb_merge = (new_v & VTB_WRITABLE) | (old_v & ~VTB_WRITABLE);
  endfunction : vtb_merge

  // If-then layout: low two bits high up, the rest at 15:10
  function automatic logic [31:0] place_if_then(input logic [7:0] v);
    logic [31:0] w;
    w = '0;
    w[CPS_COND_HI_MSB:CPS_COND_HI_LSB] = v[1:0];
    w[CPS_COND_LO_MSB:CPS_COND_LO_LSB] = v[7:2];
    place_if_then = w;
  endfunction : place_if_then

  // Continuation layout: top two bits high up, the rest at 15:10
  function automatic logic [31:0] place_cont(input logic [7:0] v);
    logic [31:0] w;
    w = '0;
    w[CPS_COND_HI_MSB:CPS_COND_HI_LSB] = v[7:6];
    w[CPS_COND_LO_MSB:CPS_COND_LO_LSB] = v[5:0];
    place_cont = w;
  endfunction : place_cont

  // Nonzero check bits mean the word holds if-then state
  function automatic logic is_if_then_form(input logic [31:0] w);
    is_if_then_form = |{w[CPS_COND_HI_MSB:CPS_COND_HI_LSB],
                        w[CPS_COND_CHK_MSB:CPS_COND_LO_LSB]};
  endfunction : is_if_then_form

  function automatic logic [7:0] take_cond(input logic [31:0] w);
    if (is_if_then_form(w))
    begin
      take_cond = {w[CPS_COND_LO_MSB:CPS_COND_LO_LSB],
                   w[CPS_COND_HI_MSB:CPS_COND_HI_LSB]};
    end
    else
    begin
      take_cond = {w[CPS_COND_HI_MSB:CPS_COND_HI_LSB],
                   w[CPS_COND_LO_MSB:CPS_COND_LO_LSB]};
    end
  endfunction : take_cond

  // ----------------------------------------------------------------
  // Live combined status view
  // ----------------------------------------------------------------
  // The core holds one of the two forms at a time; show whichever is live
  always_comb
  begin
    if (is_if_then_form(place_if_then(if_then_state_i)))
    begin
      live_cond = place_if_then(if_then_state_i);
    end
    else
    begin
      live_cond = place_cont(interrupt_continuation_i);
    end
  end

  // ----------------------------------------------------------------
  // Register access and next state
  // ----------------------------------------------------------------
  // Only whole-word accesses exist on this port, so no lane logic.
  always_comb
  begin
    nxt_state = cur_ff;
    nxt_state.rdata = '0;
    nxt_state.status_wr = 1'b0;
    ufs_clr = '0;
    irq_clr = '0;
    access_fault = 1'b0;
    if (rd_i || wr_i)
    begin
      if (addr_i == VTB_ADDR)
      begin
        if (!priv_i)
        begin
          access_fault = 1'b1;
        end
        else if (wr_i)
        begin
          if (secure_i)
          begin
            nxt_state.vtb_s = vtb_merge(cur_ff.vtb_s, wdata_i);
          end
          else
          begin
            nxt_state.vtb_ns = vtb_merge(cur_ff.vtb_ns, wdata_i);
          end
        end
        else
        begin
          nxt_state.rdata = secure_i ? cur_ff.vtb_s : cur_ff.vtb_ns;
        end
      end
      else if (addr_i == VTB_NS_ADDR)
      begin
        if (!priv_i)
        begin
          access_fault = 1'b1;
        end
        else if (secure_i && !debug_i)
        begin
          if (wr_i)
          begin
            nxt_state.vtb_ns = vtb_merge(cur_ff.vtb_ns, wdata_i);
          end
          else
          begin
            nxt_state.rdata = cur_ff.vtb_ns;
          end
        end
        // Non-secure or debugger: reads zero, writes dropped.
      end
      else if (addr_i == UFS_ADDR)
      begin
        if (!priv_i)
        begin
          access_fault = 1'b1;
        end
        else if (wr_i)
        begin
          ufs_clr = wdata_i[NUM_FAULTS-1:0];
        end
        else
        begin
          nxt_state.rdata = 32'(ufs_flags);
        end
      end
      else if (addr_i == CPS_ADDR)
      begin
        // Unprivileged: read as zero, write ignored, no fault.
        if (priv_i && wr_i)
        begin
          nxt_state.status_wr = 1'b1;
          nxt_state.app_flags = wdata_i[CPS_APP_MSB:CPS_APP_LSB];
          nxt_state.thumb = wdata_i[CPS_THUMB];
          nxt_state.gteq_flags = wdata_i[CPS_GTEQ_MSB:CPS_GTEQ_LSB];
          nxt_state.cond_is_if_then = is_if_then_form(wdata_i);
          nxt_state.cond_state = take_cond(wdata_i);
          nxt_state.exc_num = wdata_i[CPS_EXC_MSB:CPS_EXC_LSB];
        end
        else if (priv_i)
        begin
          nxt_state.rdata = live_cond;
          nxt_state.rdata[CPS_APP_MSB:CPS_APP_LSB] = application_flags_i;
          nxt_state.rdata[CPS_THUMB] = thumb_i;
          nxt_state.rdata[CPS_GTEQ_MSB:CPS_GTEQ_LSB] = greater_equal_flags_i;
          nxt_state.rdata[CPS_EXC_MSB:CPS_EXC_LSB] = exception_number_i;
        end
      end
      else if (addr_i == IRQ_STAT_ADDR)
      begin
        if (rd_i)
        begin
          nxt_state.rdata = 32'(irq_flags);
        end
      end
      else if (addr_i == IRQ_CLR_ADDR)
      begin
        if (wr_i)
        begin
          irq_clr = wdata_i[NUM_IRQ-1:0];
        end
      end
      else if (addr_i == IRQ_EN_ADDR)
      begin
        if (wr_i)
        begin
          nxt_state.irq_en = wdata_i[NUM_IRQ-1:0];
        end
        else
        begin
          nxt_state.rdata = 32'(cur_ff.irq_en);
        end
      end
      // Unmapped addresses read zero and drop writes
    end
    nxt_state.bus_fault = access_fault;
    // Registered, so the line trails the status bit by one cycle
    nxt_state.irq = |(irq_flags & cur_ff.irq_en);
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cur_ff <= STATE_RESET;
    end
    else
    begin
      cur_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flag banks
  // ----------------------------------------------------------------
  // Bit order of fault_evt_i follows the status layout.
  fault_flag_bank #(
    .WIDTH(NUM_FAULTS),
    .RESET_VALUE(FAULTS_RESET)
  ) u_usage_flags (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .set_i(fault_evt_i),
    .clr_i(ufs_clr),
    .flags_o(ufs_flags)
  );

  assign irq_set = {access_fault, fault_evt_i};

  fault_flag_bank #(
    .WIDTH(NUM_IRQ),
    .RESET_VALUE(IRQ_RESET)
  ) u_irq_flags (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .flags_o(irq_flags)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = cur_ff.rdata;
  assign bus_fault_o = cur_ff.bus_fault;
  assign status_wr_o = cur_ff.status_wr;
  assign application_flags_o = cur_ff.app_flags;
  assign greater_equal_flags_o = cur_ff.gteq_flags;
  assign thumb_o = cur_ff.thumb;
  assign cond_state_o = cur_ff.cond_state;
  assign cond_is_if_then_o = cur_ff.cond_is_if_then;
  assign exception_number_o = cur_ff.exc_num;
  assign vtb_secure_o = cur_ff.vtb_s;
  assign vtb_nonsecure_o = cur_ff.vtb_ns;
  assign usage_fault_status_o = ufs_flags;
  assign irq_o = cur_ff.irq;

endmodule : fault_vector_status_regs

`default_nettype wire

// File: rtl/fvs_pkg.sv
// Constants shared by the fault, vector table and program status register bank.
// Assumes a 32-bit byte address on a plain strobe port, one clock, sync reset.
package fvs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] VTB_ADDR = 32'hE000ED08;
  localparam logic [31:0] VTB_NS_ADDR = 32'hE002ED08;
  localparam logic [31:0] UFS_ADDR = 32'hE000ED2A;
  localparam logic [31:0] CPS_ADDR = 32'hE000EF00;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'hE000EF04;
  localparam logic [31:0] IRQ_CLR_ADDR = 32'hE000EF08;
  localparam logic [31:0] IRQ_EN_ADDR = 32'hE000EF0C;

  // ----------------------------------------------------------------
  // Usage fault flags
  // ----------------------------------------------------------------
  localparam int NUM_FAULTS = 5;
  localparam int UNKNOWN_OPCODE_BIT = 0;
  localparam int BAD_EXEC_STATE_BIT = 1;
  localparam int BAD_RETURN_BIT = 2;
  localparam int NO_COPROCESSOR_BIT = 3;
  localparam int STACK_OVERFLOW_BIT = 4;
  localparam logic [NUM_FAULTS-1:0] FAULTS_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Interrupt status: five faults plus the access fault
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 6;
  localparam int ACCESS_FAULT_BIT = 5;
  localparam logic [NUM_IRQ-1:0] IRQ_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Vector table base
  // ----------------------------------------------------------------
  localparam logic [31:0] VTB_RESET = 32'h00000000;
  localparam logic [31:0] VTB_WRITABLE = 32'hFFFFFF80;

  // ----------------------------------------------------------------
  // Combined program status layout
  // ----------------------------------------------------------------
  localparam int CPS_APP_MSB = 31;
  localparam int CPS_APP_LSB = 27;
  localparam int CPS_COND_HI_MSB = 26;
  localparam int CPS_COND_HI_LSB = 25;
  localparam int CPS_THUMB = 24;
  localparam int CPS_GTEQ_MSB = 19;
  localparam int CPS_GTEQ_LSB = 16;
  localparam int CPS_COND_LO_MSB = 15;
  localparam int CPS_COND_LO_LSB = 10;
  localparam int CPS_COND_CHK_MSB = 11;
  localparam int CPS_EXC_MSB = 8;
  localparam int CPS_EXC_LSB = 0;

endpackage : fvs_pkg

// File: rtl/fault_flag_bank.sv
// Bank of sticky flags, set by one-cycle event pulses, cleared by write-one.
// Assumes set and clear pulses are synchronous to mclk_i.
`timescale 1ns/1ps
`default_nettype none

module fault_flag_bank #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Events and clears
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // Flags
  output logic [WIDTH-1:0] flags_o
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } flag_state_type;

  flag_state_type cur_ff;
  flag_state_type nxt_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = cur_ff;
    // Set after clear, so an event in the clearing cycle is kept
    nxt_state.flags = (cur_ff.flags & ~clr_i) | set_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      cur_ff.flags <= RESET_VALUE;
    end
    else
    begin
      cur_ff <= nxt_state;
    end
  end

  assign flags_o = cur_ff.flags;

endmodule : fault_flag_bank

`default_nettype wire

// File: dv/fvs_checker_properties.sv
// Port-level assertions for the fault, vector base and status bank.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fvs_checker
  import fvs_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic priv_i,
  input wire logic secure_i,
  input wire logic debug_i,
  input wire logic [31:0] rdata_o,
  input wire logic bus_fault_o,
  // Core side
  input wire logic [NUM_FAULTS-1:0] fault_evt_i,
  input wire logic [4:0] application_flags_i,
  input wire logic [8:0] exception_number_i,
  input wire logic [31:0] vtb_secure_o,
  input wire logic [31:0] vtb_nonsecure_o,
  input wire logic [NUM_FAULTS-1:0] usage_fault_status_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // Only a privileged write may clear flags
  wire logic ufs_w = wr_i && priv_i && addr_i == UFS_ADDR;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_flag_set;
    |fault_evt_i |=> (usage_fault_status_o & $past(fault_evt_i)) == $past(fault_evt_i);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("fault event did not set its flag");
  property p_flag_hold;
    !ufs_w |=> (usage_fault_status_o & $past(usage_fault_status_o))
      == $past(usage_fault_status_o);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag fell without a clear");
  property p_w1c;
    ufs_w && fault_evt_i == '0 |=> usage_fault_status_o
      == ($past(usage_fault_status_o) & ~$past(wdata_i));
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one clear wrong");
  property p_reset;
    $fell(rst_i) |-> usage_fault_status_o == '0 && vtb_secure_o == VTB_RESET;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");
  property p_vtb_fault;
    (rd_i || wr_i) && !priv_i && (addr_i == VTB_ADDR || addr_i == VTB_NS_ADDR
      || addr_i == UFS_ADDR) |=> bus_fault_o && rdata_o == '0;
  endproperty
  a_vtb_fault: assert property (p_vtb_fault)
    else $error("unprivileged access without bus fault");
  property p_alias_zero;
    rd_i && priv_i && addr_i == VTB_NS_ADDR && (!secure_i || debug_i)
      |=> rdata_o == '0 && !bus_fault_o;
  endproperty
  a_alias_zero: assert property (p_alias_zero)
    else $error("alias not zero");
  property p_vtb_bank;
    wr_i && priv_i && secure_i && addr_i == VTB_ADDR
      |=> vtb_secure_o == ($past(wdata_i) & VTB_WRITABLE) && $stable(vtb_nonsecure_o);
  endproperty
  a_vtb_bank: assert property (p_vtb_bank)
    else $error("secure base write wrong");
  property p_cps_read;
    rd_i && priv_i && addr_i == CPS_ADDR |=> rdata_o[23:20] == 4'h0 && !rdata_o[9]
      && rdata_o[31:27] == $past(application_flags_i)
      && rdata_o[8:0] == $past(exception_number_i);
  endproperty
  a_cps_read: assert property (p_cps_read)
    else $error("status word layout wrong");
endmodule : fvs_checker

bind fault_vector_status_regs fvs_checker u_chk (.mclk_i, .rst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .priv_i, .secure_i, .debug_i, .rdata_o, .bus_fault_o, .fault_evt_i,
  .application_flags_i, .exception_number_i, .vtb_secure_o, .vtb_nonsecure_o,
  .usage_fault_status_o);
`default_nettype wire

// File: dv/core_model.sv
// Core pipeline stand-in: fault pulses on command, live status fields.
// Assumes the bank's status write pulse is loaded at the next edge.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Status write from the bank
  input wire logic load_i,
  input wire logic [4:0] app_i,
  input wire logic [3:0] gteq_i,
  input wire logic thumb_i,
  input wire logic [7:0] cond_i,
  input wire logic is_if_then_i,
  input wire logic [8:0] exc_i,
  // Events and live status
  output logic [4:0] evt_o,
  output logic [4:0] app_o,
  output logic [3:0] gteq_o,
  output logic thumb_o,
  output logic [7:0] if_then_o,
  output logic [7:0] cont_o,
  output logic [8:0] exc_o
);
  initial
  begin
    evt_o = 5'h00;
    {app_o, gteq_o, thumb_o, if_then_o, cont_o, exc_o} = '0;
  end
  // Views are exclusive, so the idle one reads zero
  always @(posedge mclk_i)
  begin
    if (rst_i)
      {app_o, gteq_o, thumb_o, if_then_o, cont_o, exc_o} <= '0;
    else if (load_i)
      {app_o, gteq_o, thumb_o, if_then_o, cont_o, exc_o} <= {app_i, gteq_i, thumb_i,
        is_if_then_i ? cond_i : 8'h00, is_if_then_i ? 8'h00 : cond_i, exc_i};
  end
  task automatic fire(input logic [4:0] k);
    @(posedge mclk_i);
    evt_o <= k;
    @(posedge mclk_i);
    evt_o <= 5'h00;
  endtask : fire
endmodule : core_model
`default_nettype wire

// File: dv/fault_vector_status_regs_bench.sv
// Self-checking bench for the fault, vector base and status bank.
// Assumes the core model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module fault_vector_status_regs_bench import fvs_pkg::*;;
  localparam logic [2:0] SP = 3'h6;
  localparam logic [2:0] NP = 3'h4;
  localparam logic [2:0] UP = 3'h2;
  localparam logic [2:0] DB = 3'h7;
  logic mclk_i, rst_i, wr_i, rd_i, priv_i, secure_i, debug_i, bus_fault_o, status_wr_o;
  logic thumb_i, thumb_o, cond_is_if_then_o, irq_o;
  logic [31:0] addr_i, wdata_i, rdata_o, vtb_secure_o, vtb_nonsecure_o;
  logic [4:0] fault_evt_i, application_flags_i, application_flags_o, usage_fault_status_o;
  logic [3:0] greater_equal_flags_i, greater_equal_flags_o;
  logic [7:0] if_then_state_i, interrupt_continuation_i, cond_state_o;
  logic [8:0] exception_number_i, exception_number_o;
  int fail_count = 0;
  int cmp_count = 0;
  fault_vector_status_regs DUT (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .priv_i, .secure_i, .debug_i, .rdata_o, .bus_fault_o, .fault_evt_i,
    .application_flags_i, .greater_equal_flags_i, .thumb_i, .if_then_state_i,
    .interrupt_continuation_i, .exception_number_i, .status_wr_o, .application_flags_o,
    .greater_equal_flags_o, .thumb_o, .cond_state_o, .cond_is_if_then_o,
    .exception_number_o, .vtb_secure_o, .vtb_nonsecure_o, .usage_fault_status_o, .irq_o);
  core_model core (.mclk_i, .rst_i, .load_i(status_wr_o), .app_i(application_flags_o),
    .gteq_i(greater_equal_flags_o), .thumb_i(thumb_o), .cond_i(cond_state_o),
    .is_if_then_i(cond_is_if_then_o), .exc_i(exception_number_o), .evt_o(fault_evt_i),
    .app_o(application_flags_i), .gteq_o(greater_equal_flags_i), .thumb_o(thumb_i),
    .if_then_o(if_then_state_i), .cont_o(interrupt_continuation_i),
    .exc_o(exception_number_i));
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic bw(input logic [31:0] a, input logic [31:0] d, input logic [2:0] m);
    @(posedge mclk_i);
    {priv_i, secure_i, debug_i} <= m;
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : bw
  task automatic rchk(input logic [31:0] a, input logic [2:0] m, input logic [31:0] e,
    input logic f);
    @(posedge mclk_i);
    {priv_i, secure_i, debug_i} <= m;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    cmp("rdata_o", e, rdata_o);
    cmp("bus_fault_o", {31'h0, f}, {31'h0, bus_fault_o});
  endtask : rchk
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    cmp("flags", 32'h0, {27'h0, usage_fault_status_o});
    cmp("vtb_secure_o", VTB_RESET, vtb_secure_o);
  endtask : do_reset
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_faults();
    int k;
    for (k = 0; k < NUM_FAULTS; k++)
    begin
      core.fire(5'h01 << k);
      #1;
      cmp("flags", (32'h2 << k) - 32'h1, {27'h0, usage_fault_status_o});
    end
    rchk(UFS_ADDR, NP, 32'h1F, 1'b0);
    rchk(UFS_ADDR, UP, 32'h0, 1'b1);
    bw(UFS_ADDR, 32'h1F, UP);
    bw(UFS_ADDR, 32'h5, NP);
    #1;
    cmp("flags", 32'h1A, {27'h0, usage_fault_status_o});
    fork
      core.fire(5'h02);
      bw(UFS_ADDR, 32'h2, NP);
    join
    #1;
    cmp("flags", 32'h1A, {27'h0, usage_fault_status_o});
  endtask : t_faults
  task automatic t_vtb();
    bw(VTB_ADDR, 32'h12345678, SP);
    bw(VTB_ADDR, 32'hABCDEFFF, NP);
    rchk(VTB_ADDR, SP, 32'h12345600, 1'b0);
    rchk(VTB_ADDR, NP, 32'hABCDEF80, 1'b0);
    rchk(VTB_NS_ADDR, SP, 32'hABCDEF80, 1'b0);
    rchk(VTB_NS_ADDR, NP, 32'h0, 1'b0);
    rchk(VTB_NS_ADDR, DB, 32'h0, 1'b0);
    bw(VTB_NS_ADDR, 32'h0, NP);
    bw(VTB_NS_ADDR, 32'h0, DB);
    bw(VTB_ADDR, 32'h0, UP);
    #1;
    cmp("vtb_nonsecure_o", 32'hABCDEF80, vtb_nonsecure_o);
    cmp("vtb_secure_o", 32'h12345600, vtb_secure_o);
    bw(VTB_NS_ADDR, 32'h00000180, SP);
    #1;
    cmp("vtb_nonsecure_o", 32'h00000180, vtb_nonsecure_o);
    rchk(32'hE000EE00, SP, 32'h0, 1'b0);
  endtask : t_vtb
  task automatic t_cps();
    bw(CPS_ADDR, 32'hABFAB7A3, NP);
    #1;
    cmp("status_wr_o", 32'h1, {31'h0, status_wr_o});
    cmp("application_flags_o", 32'h15, {27'h0, application_flags_o});
    cmp("thumb_o", 32'h1, {31'h0, thumb_o});
    cmp("greater_equal_flags_o", 32'hA, {28'h0, greater_equal_flags_o});
    cmp("cond_state_o", 32'h1B5, {23'h0, cond_is_if_then_o, cond_state_o});
    cmp("exception_number_o", 32'h1A3, {23'h0, exception_number_o});
    rchk(CPS_ADDR, NP, 32'hAB0AB5A3, 1'b0);
    rchk(CPS_ADDR, UP, 32'h0, 1'b0);
    bw(CPS_ADDR, 32'hFFFFFFFF, UP);
    #1;
    cmp("status_wr_o", 32'h0, {31'h0, status_wr_o});
    bw(CPS_ADDR, 32'h0000F000, SP);
    #1;
    cmp("cond_state_o", 32'h03C, {23'h0, cond_is_if_then_o, cond_state_o});
    rchk(CPS_ADDR, NP, 32'h0000F000, 1'b0);
  endtask : t_cps
  task automatic t_irq();
    int n;
    bw(IRQ_CLR_ADDR, 32'h3F, NP);
    bw(IRQ_EN_ADDR, 32'h01, NP);
    rchk(VTB_ADDR, UP, 32'h0, 1'b1);
    core.fire(5'h01);
    for (n = 0; n < 8 && irq_o !== 1'b1; n++)
      @(negedge mclk_i);
    cmp("irq_o", 32'h1, {31'h0, irq_o});
    if (irq_o !== 1'b1)
      tally_and_finish();
    rchk(IRQ_STAT_ADDR, NP, 32'h21, 1'b0);
    bw(IRQ_EN_ADDR, 32'h0, NP);
    repeat (2) @(posedge mclk_i);
    #1;
    cmp("irq_o", 32'h0, {31'h0, irq_o});
    bw(IRQ_CLR_ADDR, 32'h21, NP);
    bw(IRQ_EN_ADDR, 32'h3F, NP);
    repeat (2) @(posedge mclk_i);
    #1;
    cmp("irq_o", 32'h0, {31'h0, irq_o});
  endtask : t_irq
  initial
  begin
    {wr_i, rd_i, priv_i, secure_i, debug_i} = 5'h00;
    addr_i = 32'h0;
    wdata_i = 32'h0;
    do_reset();
    t_faults();
    do_reset();
    t_vtb();
    t_cps();
    t_irq();
    tally_and_finish();
  end
endmodule : fault_vector_status_regs_bench
`default_nettype wire
